// >>> adc_port.v
/*
 Serial control and readout port of a 10-bit converter, whole logic in one module.
 Assumes chip select, serial clock and address come from pins of another domain;
 the analog result arrives as a 10-bit word from the converter core.
*/
//
// Summary of operation
// - Self-test addresses return mid, zero, full codes
// - Conversion completes within twenty-one microseconds
// - Sample during six serial clock periods
// - Done goes low after tenth falling edge
// - Done rising presents result MSB on output
// - Output shifts after each serial falling edge
// - Chip select falling drives MSB out
// - Chip select rising releases the data output
// - Chip select low within nine microseconds after tenth aborts conversion
// - Chip select filtered by minimum hold time
// - Rising chip select disables address and clock
// - Address and result use positive logic
// - Frames of ten, eleven-sixteen, or sixteen
`timescale 1ns/1ps
`include "adc_port_map.vh"
`default_nettype none

module adc_port (
    input wire clk,
    input wire rst_n,
    input wire cs_n_pin,
    input wire sclk_pin,
    input wire addr_pin,
    input wire [9:0] analog_code,
    output reg dout_o,
    output reg dout_oe,
    output reg eoc_o,
    output reg [3:0] chan_sel_q,
    output reg sample_q
);

    localparam ST_IDLE = 3'b001;
    localparam ST_CONV = 3'b010;
    localparam ST_DONE = 3'b100;

    // ----------------------------------------
    // Input synchronisers
    // ----------------------------------------
    reg [1:0] cs_sync_q;
    reg [1:0] sclk_sync_q;
    reg [1:0] addr_sync_q;
    reg sclk_prev_q;
    reg cs_filt_q;
    reg [6:0] cs_cnt_q;
    reg [2:0] state_q;
    reg [4:0] fall_cnt_q;
    reg [4:0] rise_cnt_q;
    reg [3:0] addr_sh_q;
    reg [9:0] out_sh_q;
    reg [9:0] result_q;
    reg [10:0] conv_cnt_q;
    reg [8:0] abort_cnt_q;
    reg cs_filt_prev_q;

    // Two flops per pin; only the second stage feeds logic
    always @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            cs_sync_q <= 2'b11;
            sclk_sync_q <= 2'b00;
            addr_sync_q <= 2'b00;
            sclk_prev_q <= 1'b0;
        end else begin
            cs_sync_q <= {cs_sync_q[0], cs_n_pin};
            sclk_sync_q <= {sclk_sync_q[0], sclk_pin};
            addr_sync_q <= {addr_sync_q[0], addr_pin};
            sclk_prev_q <= sclk_sync_q[1];
        end
    end

    wire cs_sync = cs_sync_q[1];
    wire sclk_rise = sclk_sync_q[1] & ~sclk_prev_q;
    wire sclk_fall = ~sclk_sync_q[1] & sclk_prev_q;

    // ----------------------------------------
    // Chip select glitch filter
    // ----------------------------------------
    // New level counts only once held long enough; kills short noise pulses
    always @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            cs_filt_q <= 1'b1;
            cs_cnt_q <= 7'h00;
            cs_filt_prev_q <= 1'b1;
        end else begin
            cs_filt_prev_q <= cs_filt_q;
            if (cs_sync == cs_filt_q) begin
                cs_cnt_q <= 7'h00;
            end else if (cs_cnt_q == `CS_FILT_LAST) begin
                cs_filt_q <= cs_sync;
                cs_cnt_q <= 7'h00;
            end else begin
                cs_cnt_q <= cs_cnt_q + 7'h01;
            end
        end
    end

    wire cs_fall = ~cs_filt_q & cs_filt_prev_q;
    wire cs_rise = cs_filt_q & ~cs_filt_prev_q;
    // Clock and address gated by filtered select; tied-low select enables always
    wire active = ~cs_filt_q;

    // Self-test sources replace the analog word
    function [9:0] pick_code;
        input [3:0] ch;
        input [9:0] code;
        begin
            case (ch)
                `SELF_MID: pick_code = `CODE_MID;
                `SELF_ZERO: pick_code = `CODE_ZERO;
                `SELF_FULL: pick_code = `CODE_FULL;
                default: pick_code = code;
            endcase
        end
    endfunction

    wire tenth_fall = active & sclk_fall & (fall_cnt_q == `SAMPLE_END - 5'h01);

    // ----------------------------------------
    // Serial shift, sampling and conversion
    // ----------------------------------------
    // Edge counters restart on each select fall, or after sixteen clocks
    always @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            state_q <= ST_IDLE;
            fall_cnt_q <= 5'h00;
            rise_cnt_q <= 5'h00;
            addr_sh_q <= 4'h0;
            out_sh_q <= 10'h000;
            result_q <= 10'h000;
            conv_cnt_q <= 11'h000;
            abort_cnt_q <= 9'h000;
            chan_sel_q <= 4'h0;
            sample_q <= 1'b0;
            eoc_o <= 1'b1;
            dout_o <= 1'b0;
            dout_oe <= 1'b0;
        end else begin
            // Enable follows the synchronised pin: the filter is too slow for it
            dout_oe <= ~cs_sync;
            if (cs_rise) begin
                fall_cnt_q <= 5'h00;
                rise_cnt_q <= 5'h00;
                sample_q <= 1'b0;
            end
            if (cs_fall) begin
                out_sh_q <= result_q;
                dout_o <= result_q[9];
                fall_cnt_q <= 5'h00;
                rise_cnt_q <= 5'h00;
                if (state_q == ST_CONV && abort_cnt_q != `ABORT_LAST) begin
                    state_q <= ST_IDLE;
                    eoc_o <= 1'b1;
                end
            end else if (active) begin
                if (sclk_rise && rise_cnt_q < `FULL_FRAME) begin
                    rise_cnt_q <= rise_cnt_q + 5'h01;
                    if (rise_cnt_q < `ADDR_BITS) begin
                        addr_sh_q <= {addr_sh_q[2:0], addr_sync_q[1]};
                    end
                end
                if (sclk_fall && fall_cnt_q < `FULL_FRAME) begin
                    fall_cnt_q <= fall_cnt_q + 5'h01;
                    out_sh_q <= {out_sh_q[8:0], 1'b0};
                    dout_o <= out_sh_q[8];
                    if (fall_cnt_q == `SAMPLE_START - 5'h01) begin
                        chan_sel_q <= addr_sh_q;
                        sample_q <= 1'b1;
                    end
                end
                // Sixteen-clock frame without select wraps for the next one
                if (sclk_fall && fall_cnt_q == `FULL_FRAME - 5'h01) begin
                    fall_cnt_q <= 5'h00;
                    rise_cnt_q <= 5'h00;
                end
            end else begin
                // Deselected: keep the MSB ready for the fast output enable
                out_sh_q <= result_q;
                dout_o <= result_q[9];
            end
            case (state_q)
                ST_IDLE: begin
                    if (tenth_fall) begin
                        sample_q <= 1'b0;
                        eoc_o <= 1'b0;
                        conv_cnt_q <= 11'h000;
                        abort_cnt_q <= 9'h000;
                        state_q <= ST_CONV;
                    end
                end
                ST_CONV: begin
                    // Abort window counter; a late select fall no longer abandons
                    if (abort_cnt_q != `ABORT_LAST) begin
                        abort_cnt_q <= abort_cnt_q + 9'h001;
                    end
                    if (conv_cnt_q == `CONV_LAST) begin
                        result_q <= pick_code(chan_sel_q, analog_code);
                        state_q <= ST_DONE;
                    end else begin
                        conv_cnt_q <= conv_cnt_q + 11'h001;
                    end
                end
                ST_DONE: begin
                    eoc_o <= 1'b1;
                    out_sh_q <= result_q;
                    dout_o <= result_q[9];
                    state_q <= ST_IDLE;
                end
                default: state_q <= ST_IDLE;
            endcase
        end
    end

endmodule // adc_port

`default_nettype wire

// >>> adc_port_map.vh
/*
 Constants for the serial converter control port: timing counts, codes,
 transfer lengths. Assumes a 50 MHz system clock.
*/
`ifndef ADC_PORT_MAP_VH
`define ADC_PORT_MAP_VH

`define CLK_NS 20
`define CONV_TIME_NS 21000
`define CONV_CYCLES (`CONV_TIME_NS / `CLK_NS)
// Last conversion count: a few cycles under 1050 leave room for the pin synchronisers
`define CONV_LAST 11'h414
`define ABORT_WIN_NS 9000
`define ABORT_CYCLES (`ABORT_WIN_NS / `CLK_NS)
`define ABORT_LAST 9'h1C2
`define CS_FILT_NS 1425
`define CS_FILT_CYCLES ((`CS_FILT_NS + `CLK_NS - 1) / `CLK_NS)
// Last count of the select filter, 72 cycles held
`define CS_FILT_LAST 7'h47
`define ACQ_CLOCKS 4'h6
`define SAMPLE_START 5'h04
`define SAMPLE_END 5'h0A
`define FULL_FRAME 5'h10
`define ADDR_BITS 5'h04
`define RES_BITS 10
`define SELF_MID 4'hB
`define SELF_ZERO 4'hC
`define SELF_FULL 4'hD
`define CODE_MID 10'h200
`define CODE_ZERO 10'h000
`define CODE_FULL 10'h3FF

`endif

// >>> adc_port_monitor.sv
/* Checker on the converter port pins.
   Assumes one clock domain; bound below. */
`timescale 1ns/1ps
`default_nettype none
module adc_port_monitor (
    input wire logic clk,
    input wire logic rst_n,
    input wire logic cs_n_pin,
    input wire logic dout_o,
    input wire logic dout_oe,
    input wire logic eoc_o,
    input wire logic [3:0] chan_sel_q,
    input wire logic sample_q
);
    logic [10:0] busy_q, lo_q, hi_q;
    // Run lengths of busy and of each select level; saturate so long runs never wrap
    always @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            busy_q <= '0;
            lo_q <= '0;
            hi_q <= '0;
        end else begin
            busy_q <= eoc_o ? '0 : busy_q + {10'h000, ~&busy_q};
            lo_q <= cs_n_pin ? '0 : lo_q + {10'h000, ~&lo_q};
            hi_q <= cs_n_pin ? hi_q + {10'h000, ~&hi_q} : '0;
        end
    end
    default clocking @(posedge clk); endclocking
    default disable iff (!rst_n);
    a_conv_bound: assert property (!eoc_o |-> busy_q < 11'h41A)
        else $error("conversion overran");
    a_done_low: assert property ($fell(sample_q) |-> ##[0:2] !eoc_o)
        else $error("done stayed high");
    a_done_msb: assert property (
        $rose(eoc_o) && dout_oe && chan_sel_q == 4'hD |-> ##[0:5] dout_o)
        else $error("full code msb missing");
    a_zero_code: assert property ($rose(dout_oe) && chan_sel_q == 4'hC |-> !dout_o)
        else $error("zero code msb wrong");
    a_oe_off: assert property (hi_q >= 11'h007 |-> !dout_oe)
        else $error("output not released");
    a_oe_on: assert property (lo_q == 11'h008 |-> dout_oe)
        else $error("output not enabled");
    a_cs_filter: assert property ($rose(sample_q) |-> lo_q >= 11'h048)
        else $error("select taken too early");
    a_addr_ignored: assert property (hi_q > 11'h052 |=> $stable(chan_sel_q) && !sample_q)
        else $error("deselected pins used");
    a_abort_conv: assert property (lo_q == 11'h050 |-> eoc_o)
        else $error("conversion not abandoned");
    c_conv: cover property ($fell(eoc_o));
    c_tied: cover property (dout_oe && $rose(eoc_o));
    c_zero: cover property ($rose(dout_oe) && chan_sel_q == 4'hC);
endmodule // adc_port_monitor
bind adc_port adc_port_monitor mon_u (.*);
`default_nettype wire

// >>> host_port.sv
/* Host serial port model.
   Assumes the 50 MHz bench clock and a resolved data line. */
`timescale 1ns/1ps
`default_nettype none
module host_port (
    input wire logic clk,
    input wire logic dout_w,
    output logic cs_n = 1'b1,
    output logic sclk = 1'b0,
    output logic addr = 1'b0,
    output logic [9:0] rx_word = 10'h000,
    output logic rx_stb = 1'b0
);
    // Pins move 2 ns after the edge
    task automatic tick(input int k);
        repeat (k) @(posedge clk);
        #2;
    endtask
    // Select, wait out the filter, then n clocks of 160 ns
    task automatic xfer(input logic [3:0] a, input int n, input bit keep_low);
        logic [15:0] r;
        r = 16'h0000;
        cs_n = 1'b0;
        tick(80);
        for (int i = 0; i < n; i++) begin
            addr = (i < 4) ? a[3 - i] : 1'($urandom);
            tick(4);
            sclk = 1'b1;
            tick(4);
            r = {r[14:0], dout_w};
            sclk = 1'b0;
        end
        tick(4);
        cs_n = !keep_low;
        tick(80);
        rx_word = 10'(r >> (n - 10));
        rx_stb = 1'b1;
        tick(1);
        rx_stb = 1'b0;
    endtask
    // Short select pulse with clocks inside it, then clocks while deselected
    task automatic glitch();
        cs_n = 1'b0;
        repeat (8) begin
            sclk = ~sclk;
            addr = 1'($urandom);
            tick(4);
        end
        cs_n = 1'b1;
        tick(90);
        repeat (8) begin
            sclk = ~sclk;
            addr = 1'($urandom);
            tick(4);
        end
    endtask
endmodule // host_port
`default_nettype wire

// >>> tb_top.sv
/* Bench: host model sends frames, a watcher compares words.
   Assumes port, checker and host compiled first. */
`timescale 1ns/1ps
`default_nettype none
module tb_top;
    logic clk = 1'b0;
    logic rst_n = 1'b0;
    logic last_q = 1'b0;
    logic [9:0] analog_code = 10'h000;
    logic [9:0] res_q = 10'h000;
    logic [9:0] exp_q[$];
    logic cs_n, sclk, addr, dout_o, dout_oe, eoc_o, sample_q, rx_stb;
    logic [3:0] chan_sel_q;
    logic [9:0] rx_word;
    int n_mismatch = 0;
    int num_checks = 0;
    // Released line shows the inverse of its last bit
    wire dout_w = dout_oe ? dout_o : ~last_q;
    initial forever #10 clk = ~clk;
    always @(posedge clk) if (dout_oe) last_q <= dout_o;
    adc_port dut_u (.clk(clk), .rst_n(rst_n), .cs_n_pin(cs_n), .sclk_pin(sclk),
        .addr_pin(addr), .analog_code(analog_code), .dout_o(dout_o), .dout_oe(dout_oe),
        .eoc_o(eoc_o), .chan_sel_q(chan_sel_q), .sample_q(sample_q));
    host_port host_u (.clk(clk), .dout_w(dout_w), .cs_n(cs_n), .sclk(sclk),
        .addr(addr), .rx_word(rx_word), .rx_stb(rx_stb));
    task automatic check(input string what, input logic [9:0] seen, input logic [9:0] want);
        num_checks++;
        if (seen !== want) begin
            n_mismatch++;
            $display("BAD %s expected %h seen %h", what, want, seen);
        end
    endtask
    task automatic end_of_test();
        if (n_mismatch == 0 && num_checks > 0) begin
            $display("verification passed");
        end else begin
            $display("verification failed");
        end
        $finish;
    endtask
    // Note the word this frame returns, then what its conversion leaves
    task automatic frame(input logic [3:0] a, input int n, input bit keep_low, input bit done);
        exp_q.push_back(res_q);
        analog_code = 10'($urandom);
        host_u.xfer(a, n, keep_low);
        check("chan", {6'h00, chan_sel_q}, {6'h00, a});
        if (done) begin
            check("busy", {9'h000, eoc_o}, 10'h000);
            for (int k = 0; k < 1100 && eoc_o !== 1'b1; k++) host_u.tick(1);
            check("done", {9'h000, eoc_o}, 10'h001);
            res_q = (a == 4'hB) ? 10'h200 : (a == 4'hC) ? 10'h000 :
                (a == 4'hD) ? 10'h3FF : analog_code;
        end
    endtask
    always @(posedge rx_stb) check("word", rx_word, exp_q.pop_front());
    initial begin
        logic [3:0] sel [6] = '{4'hB, 4'hC, 4'hD, 4'h0, 4'hC, 4'h0};
        void'($urandom(6856));
        repeat (10) @(posedge clk);
        #2;
        rst_n = 1'b1;
        host_u.tick(4);
        host_u.glitch();
        for (int k = 0; k < 6; k++) begin
            frame(sel[k] == 4'h0 ? 4'($urandom_range(10)) : sel[k], 10 + k, 1'b0, 1'b1);
        end
        frame(4'h3, 10, 1'b0, 1'b0);
        frame(4'hD, 12, 1'b0, 1'b1);
        frame(4'hD, 16, 1'b1, 1'b1);
        frame(4'hC, 16, 1'b1, 1'b1);
        frame(4'h7, 16, 1'b0, 1'b1);
        end_of_test();
    end
    // Watchdog well beyond the expected run
    initial begin
        #1000000;
        n_mismatch++;
        end_of_test();
    end
endmodule // tb_top
`default_nettype wire
